// ### hw/fbo_pkg.sv
/*
 * Package for the flag and bit operations unit: operation codes, the request
 * carrier, status flag bit positions, register offsets and reset values.
 * Assumes that the decoder and the design files refer to every item here
 * by the package name and import nothing.
 */
package fbo_pkg;

	// Widths of the datapath.
	localparam int unsigned DATA_W = 8;
	localparam int unsigned RIDX_W = 5;
	localparam int unsigned BIDX_W = 3;
	localparam int unsigned ADDR_W = 2;

	// Positions of the flags inside the status flags register.
	localparam logic [2:0] FLAG_CARRY = 3'h0;
	localparam logic [2:0] FLAG_ZERO = 3'h1;
	localparam logic [2:0] FLAG_NEG = 3'h2;
	localparam logic [2:0] FLAG_OVF = 3'h3;
	localparam logic [2:0] FLAG_SIGN = 3'h4;
	localparam logic [2:0] FLAG_HALF = 3'h5;
	localparam logic [2:0] FLAG_XFER = 3'h6;
	localparam logic [2:0] FLAG_IEN = 3'h7;

	// Flags that the rotate and the arithmetic shift recompute.
	localparam logic [7:0] SHIFT_FLAG_MASK = 8'h0F;

	// Reset values.
	localparam logic [7:0] FLAGS_RST = 8'h00;
	localparam logic [7:0] RESULT_RST = 8'h00;

	// Register offsets on the software port.
	localparam logic [1:0] OFS_FLAGS = 2'h0;
	localparam logic [1:0] OFS_RESULT = 2'h1;

	// Operations of this group.
	typedef enum logic [4:0] {
		OP_NOP = 5'h00,
		OP_ROTATE_RIGHT_CARRY = 5'h01,
		OP_ARITH_SHIFT_RIGHT = 5'h02,
		OP_NIBBLE_SWAP = 5'h03,
		OP_FLAG_SET = 5'h04,
		OP_FLAG_CLEAR = 5'h05,
		OP_T_STORE = 5'h06,
		OP_T_LOAD = 5'h07,
		OP_CARRY_SET = 5'h08,
		OP_CARRY_CLEAR = 5'h09,
		OP_NEG_SET = 5'h0A,
		OP_NEG_CLEAR = 5'h0B,
		OP_ZERO_SET = 5'h0C,
		OP_ZERO_CLEAR = 5'h0D,
		OP_INT_ENABLE = 5'h0E,
		OP_INT_DISABLE = 5'h0F,
		OP_SIGN_SET = 5'h10,
		OP_SIGN_CLEAR = 5'h11,
		OP_OVF_SET = 5'h12,
		OP_OVF_CLEAR = 5'h13,
		OP_T_SET = 5'h14
	} fbo_op_e;

	// One instruction as the decoder hands it over.
	typedef struct packed {
		fbo_op_e op;
		logic [7:0] dst_val;
		logic [7:0] src_val;
		logic [4:0] dst_idx;
		logic [2:0] bit_idx;
	} fbo_req_s;

	// Flag update handed from the datapath to the flag register.
	typedef struct packed {
		logic [7:0] mask;
		logic [7:0] value;
	} fbo_flag_upd_s;

endpackage

// ### hw/fbo_flag_reg.sv
/*
 * Status flags register of the core. Bits under the update mask take the
 * update value; the other bits hold, unless software writes the register in
 * a cycle with no instruction update, when the whole byte is loaded.
 * Assumes one clock, mclk_i, and a synchronous active high reset.
 */
`timescale 1ns/1ps

module fbo_flag_reg (
	// Clock and reset.
	input wire logic mclk_i,
	input wire logic srst_i,
	// Instruction update.
	input wire fbo_pkg::fbo_flag_upd_s upd_i,
	// Software write.
	input wire logic sw_we_i,
	input wire logic [7:0] sw_data_i,
	// Current flags.
	output logic [7:0] flags_o
);

	logic [7:0] flags_reg;
	logic [7:0] flags_next;
	wire logic upd_any = |upd_i.mask;
	wire logic [7:0] merged = (flags_reg & ~upd_i.mask) | (upd_i.value & upd_i.mask);

	// An instruction update wins over a software write in the same cycle.
	assign flags_next = upd_any ? merged : (sw_we_i ? sw_data_i : flags_reg);

	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			flags_reg <= fbo_pkg::FLAGS_RST;
		end else begin
			flags_reg <= flags_next;
		end
	end

	assign flags_o = flags_reg;

	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (srst_i);

	unmasked_hold_a: assert property (upd_any |=>
		((flags_o ^ $past(flags_reg)) & ~$past(upd_i.mask)) == 8'h00)
		else $error("flag outside the update mask changed");

	idle_hold_a: assert property (!upd_any && !sw_we_i |=> $stable(flags_o))
		else $error("flags changed without an update");

endmodule

// ### hw/fbo_unit.sv
/*
 * Flag and bit operations unit: rotate right through carry, arithmetic shift
 * right, nibble swap, transfer bit store and load, and the status flag set and
 * clear instructions, with the status flags register and a small software port.
 * Assumes the decoder supplies operand values already read from the working
 * registers, and writes res_data_o back to register res_idx_o when res_we_o.
 */
// Summary of operation
// - Rotate right: bit 7 takes old carry, carry takes old bit 0.
// - Arithmetic shift right: bits 0 to 6 take next higher bit, bit 7 kept.
// - Nibble swap exchanges upper and lower four bits of the destination.
// - Flag set/clear writes one/zero into indexed flag; others unchanged.
// - Transfer store copies selected source bit into transfer flag only.
// - Transfer load copies transfer flag into selected destination bit only.
// - Carry set forces carry to one, carry clear to zero; nothing else.
// - Negative set/clear forces negative flag to one/zero only.
// - Zero set/clear forces zero flag to one/zero only.
// - Interrupt enable sets, interrupt disable clears, the global enable flag only.
// - Signed set/clear forces the signed test flag to one/zero only.
// - Overflow set/clear forces the overflow flag to one/zero only.
// - Transfer set forces transfer flag to one, all other flags unchanged.
// - Rotate updates zero, carry, negative, overflow; swap and load touch no flag.
`timescale 1ns/1ps

module fbo_unit (
	// Clock and reset.
	input wire logic mclk_i,
	input wire logic srst_i,
	// Instruction from the decoder.
	input wire logic req_valid_i,
	input wire fbo_pkg::fbo_req_s req_i,
	// Register write back.
	output logic res_we_o,
	output logic [4:0] res_idx_o,
	output logic [7:0] res_data_o,
	// Status flags.
	output logic [7:0] flags_o,
	// Software register port.
	input wire logic [1:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_we_i,
	input wire logic reg_re_i,
	output logic [7:0] reg_rdata_o
);

	// Single bit decode of a three bit index.
	function automatic logic [7:0] bit_sel(input logic [2:0] idx);
		bit_sel = 8'h01 << idx;
	endfunction

	// Replace one bit of a byte.
	function automatic logic [7:0] put_bit(input logic [7:0] val, input logic [2:0] idx,
		input logic b);
		put_bit = (val & ~bit_sel(idx)) | ({8{b}} & bit_sel(idx));
	endfunction

	// Flags recomputed by a shift: zero, carry from bit 0, negative, overflow.
	function automatic logic [7:0] shift_flags(input logic [7:0] res, input logic c);
		logic [7:0] f;
		f = 8'h00;
		f[fbo_pkg::FLAG_CARRY] = c;
		f[fbo_pkg::FLAG_ZERO] = (res == 8'h00);
		f[fbo_pkg::FLAG_NEG] = res[7];
		f[fbo_pkg::FLAG_OVF] = res[7] ^ c;
		shift_flags = f;
	endfunction

	logic [7:0] res_data_reg;
	logic [7:0] res_data_next;
	logic res_we_reg;
	logic res_we_next;
	logic [4:0] res_idx_reg;
	logic [7:0] rdata_reg;
	logic [7:0] rdata_next;
	logic [7:0] flags;
	fbo_pkg::fbo_flag_upd_s upd;

	wire fbo_pkg::fbo_op_e op = req_valid_i ? req_i.op : fbo_pkg::OP_NOP;
	wire logic [7:0] dst = req_i.dst_val;
	wire logic old_c = flags[fbo_pkg::FLAG_CARRY];
	wire logic old_t = flags[fbo_pkg::FLAG_XFER];

	// Data results of the register writing operations.
	wire logic [7:0] rotc_res = {old_c, dst[7:1]};
	wire logic [7:0] ashr_res = {dst[7], dst[7:1]};
	wire logic [7:0] swap_res = {dst[3:0], dst[7:4]};
	wire logic [7:0] tld_res = put_bit(dst, req_i.bit_idx, old_t);

	wire logic is_rotc = (op == fbo_pkg::OP_ROTATE_RIGHT_CARRY);
	wire logic is_ashr = (op == fbo_pkg::OP_ARITH_SHIFT_RIGHT);
	wire logic is_swap = (op == fbo_pkg::OP_NIBBLE_SWAP);
	wire logic is_tld = (op == fbo_pkg::OP_T_LOAD);

	// Only the four register writing operations produce a write back.
	assign res_we_next = is_rotc | is_ashr | is_swap | is_tld;
	assign res_data_next = is_rotc ? rotc_res :
		is_ashr ? ashr_res :
		is_swap ? swap_res :
		is_tld ? tld_res : res_data_reg;

	// Flag update: a mask of touched flags and their new values.
	always_comb begin
		upd.mask = 8'h00;
		upd.value = 8'h00;
		unique case (op)
			fbo_pkg::OP_NOP, fbo_pkg::OP_NIBBLE_SWAP, fbo_pkg::OP_T_LOAD: begin
				upd.mask = 8'h00;
			end
			fbo_pkg::OP_ROTATE_RIGHT_CARRY: begin
				upd.mask = fbo_pkg::SHIFT_FLAG_MASK;
				upd.value = shift_flags(rotc_res, dst[0]);
			end
			fbo_pkg::OP_ARITH_SHIFT_RIGHT: begin
				upd.mask = fbo_pkg::SHIFT_FLAG_MASK;
				upd.value = shift_flags(ashr_res, dst[0]);
			end
			fbo_pkg::OP_FLAG_SET: begin
				upd.mask = bit_sel(req_i.bit_idx);
				upd.value = 8'hFF;
			end
			fbo_pkg::OP_FLAG_CLEAR: begin
				upd.mask = bit_sel(req_i.bit_idx);
			end
			fbo_pkg::OP_T_STORE: begin
				upd.mask = bit_sel(fbo_pkg::FLAG_XFER);
				upd.value = {8{req_i.src_val[req_i.bit_idx]}};
			end
			fbo_pkg::OP_CARRY_SET, fbo_pkg::OP_CARRY_CLEAR: begin
				upd.mask = bit_sel(fbo_pkg::FLAG_CARRY);
				upd.value = {8{op == fbo_pkg::OP_CARRY_SET}};
			end
			fbo_pkg::OP_NEG_SET, fbo_pkg::OP_NEG_CLEAR: begin
				upd.mask = bit_sel(fbo_pkg::FLAG_NEG);
				upd.value = {8{op == fbo_pkg::OP_NEG_SET}};
			end
			fbo_pkg::OP_ZERO_SET, fbo_pkg::OP_ZERO_CLEAR: begin
				upd.mask = bit_sel(fbo_pkg::FLAG_ZERO);
				upd.value = {8{op == fbo_pkg::OP_ZERO_SET}};
			end
			fbo_pkg::OP_INT_ENABLE, fbo_pkg::OP_INT_DISABLE: begin
				upd.mask = bit_sel(fbo_pkg::FLAG_IEN);
				upd.value = {8{op == fbo_pkg::OP_INT_ENABLE}};
			end
			fbo_pkg::OP_SIGN_SET, fbo_pkg::OP_SIGN_CLEAR: begin
				upd.mask = bit_sel(fbo_pkg::FLAG_SIGN);
				upd.value = {8{op == fbo_pkg::OP_SIGN_SET}};
			end
			fbo_pkg::OP_OVF_SET, fbo_pkg::OP_OVF_CLEAR: begin
				upd.mask = bit_sel(fbo_pkg::FLAG_OVF);
				upd.value = {8{op == fbo_pkg::OP_OVF_SET}};
			end
			fbo_pkg::OP_T_SET: begin
				upd.mask = bit_sel(fbo_pkg::FLAG_XFER);
				upd.value = 8'hFF;
			end
			default: begin
				upd.mask = 8'h00;
			end
		endcase
	end

	// Software port decode.
	wire logic sel_flags = (reg_addr_i == fbo_pkg::OFS_FLAGS);
	wire logic sel_result = (reg_addr_i == fbo_pkg::OFS_RESULT);
	wire logic flags_we = reg_we_i & sel_flags;
	assign rdata_next = !reg_re_i ? 8'h00 :
		sel_flags ? flags :
		sel_result ? res_data_reg : 8'h00;

	fbo_flag_reg u_flags (
		.mclk_i(mclk_i),
		.srst_i(srst_i),
		.upd_i(upd),
		.sw_we_i(flags_we),
		.sw_data_i(reg_wdata_i),
		.flags_o(flags)
	);

	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			res_data_reg <= fbo_pkg::RESULT_RST;
			res_we_reg <= 1'b0;
			res_idx_reg <= 5'h00;
			rdata_reg <= 8'h00;
		end else begin
			res_data_reg <= res_data_next;
			res_we_reg <= res_we_next;
			res_idx_reg <= req_i.dst_idx;
			rdata_reg <= rdata_next;
		end
	end

	assign res_we_o = res_we_reg;
	assign res_idx_o = res_idx_reg;
	assign res_data_o = res_data_reg;
	assign flags_o = flags;
	assign reg_rdata_o = rdata_reg;

	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (srst_i);

	rotc_data_a: assert property (is_rotc |=> res_we_o &&
		res_data_o == {$past(old_c), $past(dst[7:1])})
		else $error("rotate result wrong");
	rotc_carry_a: assert property (is_rotc |=>
		flags_o[fbo_pkg::FLAG_CARRY] == $past(dst[0]))
		else $error("rotate carry wrong");
	ashr_sign_a: assert property (is_ashr |=> res_data_o[7] == $past(dst[7]) &&
		res_data_o[6:0] == $past(dst[7:1]))
		else $error("arithmetic shift result wrong");
	swap_data_a: assert property (is_swap |=>
		res_data_o == {$past(dst[3:0]), $past(dst[7:4])})
		else $error("nibble swap result wrong");
	fset_bit_a: assert property (op == fbo_pkg::OP_FLAG_SET |=>
		flags_o == ($past(flags) | bit_sel($past(req_i.bit_idx))))
		else $error("flag set wrong");
	fclr_bit_a: assert property (op == fbo_pkg::OP_FLAG_CLEAR |=>
		flags_o == ($past(flags) & ~bit_sel($past(req_i.bit_idx))))
		else $error("flag clear wrong");
	tstore_copy_a: assert property (op == fbo_pkg::OP_T_STORE |=>
		flags_o == put_bit($past(flags), 3'h6, $past(req_i.src_val[req_i.bit_idx])))
		else $error("transfer store wrong");
	tload_copy_a: assert property (is_tld && !flags_we |=>
		res_data_o == put_bit($past(dst), $past(req_i.bit_idx), $past(old_t))
		&& $stable(flags_o))
		else $error("transfer load wrong");
	carry_ops_a: assert property (op == fbo_pkg::OP_CARRY_CLEAR |=>
		flags_o == ($past(flags) & 8'hFE))
		else $error("carry clear wrong");
	neg_ops_a: assert property (op == fbo_pkg::OP_NEG_SET |=>
		flags_o == ($past(flags) | 8'h04))
		else $error("negative set wrong");
	zero_ops_a: assert property (op == fbo_pkg::OP_ZERO_SET |=>
		flags_o == ($past(flags) | 8'h02))
		else $error("zero set wrong");
	int_ops_a: assert property (op == fbo_pkg::OP_INT_DISABLE |=>
		flags_o == ($past(flags) & 8'h7F))
		else $error("interrupt disable wrong");
	sign_ops_a: assert property (op == fbo_pkg::OP_SIGN_SET |=>
		flags_o == ($past(flags) | 8'h10))
		else $error("signed set wrong");
	ovf_ops_a: assert property (op == fbo_pkg::OP_OVF_CLEAR |=>
		flags_o == ($past(flags) & 8'hF7))
		else $error("overflow clear wrong");
	tset_flag_a: assert property (op == fbo_pkg::OP_T_SET |=>
		flags_o == ($past(flags) | 8'h40))
		else $error("transfer set wrong");
	swap_flags_a: assert property (is_swap && !flags_we |=> $stable(flags_o))
		else $error("nibble swap changed flags");
	rotc_flags_a: assert property (is_rotc |=> flags_o[7:4] == $past(flags[7:4]) &&
		flags_o[1] == (res_data_o == 8'h00) && flags_o[2] == res_data_o[7])
		else $error("rotate flags wrong");
	one_cycle_a: assert property (res_we_next |=> res_we_o ##1
		(res_we_o == $past(res_we_next)))
		else $error("write back not one cycle");

	// Each single flag instruction moves its own flag and leaves the rest alone.
	carry_set_a: assert property (op == fbo_pkg::OP_CARRY_SET |=>
		flags_o == ($past(flags) | bit_sel(fbo_pkg::FLAG_CARRY)))
		else $error("carry set wrong");
	neg_clear_a: assert property (op == fbo_pkg::OP_NEG_CLEAR |=>
		flags_o == ($past(flags) & ~bit_sel(fbo_pkg::FLAG_NEG)))
		else $error("negative clear wrong");
	zero_clear_a: assert property (op == fbo_pkg::OP_ZERO_CLEAR |=>
		flags_o == ($past(flags) & ~bit_sel(fbo_pkg::FLAG_ZERO)))
		else $error("zero clear wrong");
	int_enable_a: assert property (op == fbo_pkg::OP_INT_ENABLE |=>
		flags_o == ($past(flags) | bit_sel(fbo_pkg::FLAG_IEN)))
		else $error("interrupt enable wrong");
	sign_clear_a: assert property (op == fbo_pkg::OP_SIGN_CLEAR |=>
		flags_o == ($past(flags) & ~bit_sel(fbo_pkg::FLAG_SIGN)))
		else $error("signed clear wrong");
	ovf_set_a: assert property (op == fbo_pkg::OP_OVF_SET |=>
		flags_o == ($past(flags) | bit_sel(fbo_pkg::FLAG_OVF)))
		else $error("overflow set wrong");

	// Flag instructions never write a working register.
	tstore_quiet_a: assert property (op == fbo_pkg::OP_T_STORE |=> !res_we_o)
		else $error("transfer store wrote a register");
	flag_quiet_a: assert property ((op == fbo_pkg::OP_FLAG_SET) ||
		(op == fbo_pkg::OP_FLAG_CLEAR) |=> !res_we_o)
		else $error("flag operation wrote a register");
	tset_quiet_a: assert property (op == fbo_pkg::OP_T_SET |=> !res_we_o)
		else $error("transfer set wrote a register");

	// Register writing operations and their flags.
	swap_wb_a: assert property (is_swap |=> res_we_o)
		else $error("nibble swap not written back");
	tload_wb_a: assert property (is_tld |=> res_we_o)
		else $error("transfer load not written back");
	rotc_ovf_a: assert property (is_rotc |=>
		flags_o[fbo_pkg::FLAG_OVF] ==
		(flags_o[fbo_pkg::FLAG_NEG] ^ flags_o[fbo_pkg::FLAG_CARRY]))
		else $error("rotate overflow flag wrong");
	ashr_flags_a: assert property (is_ashr |=>
		flags_o[7:4] == $past(flags[7:4]) && flags_o[fbo_pkg::FLAG_CARRY] == $past(dst[0]) &&
		flags_o[fbo_pkg::FLAG_ZERO] == (res_data_o == 8'h00) &&
		flags_o[fbo_pkg::FLAG_NEG] == res_data_o[7])
		else $error("arithmetic shift flags wrong");
	wb_index_a: assert property (res_we_next |=> res_idx_o == $past(req_i.dst_idx))
		else $error("write back index wrong");
	wb_quiet_a: assert property (!res_we_next |=> !res_we_o && $stable(res_data_o))
		else $error("write back without a register operation");

	rotc_pair_c: cover property (is_rotc ##1 is_rotc);
	tset_load_c: cover property (op == fbo_pkg::OP_T_SET ##2 is_tld);
	tstore_load_c: cover property (op == fbo_pkg::OP_T_STORE ##1 is_tld);
	fset_clr_c: cover property (op == fbo_pkg::OP_FLAG_SET ##1 op == fbo_pkg::OP_FLAG_CLEAR);
	sw_write_c: cover property (flags_we ##1 reg_re_i && sel_flags);

endmodule

// ### testbench/fbo_regfile_model.sv
/*
 * Working register file on the decoder side of the unit: takes write backs
 * and lets the bench read any register back.
 * Assumes the write back strobe is a one cycle pulse on mclk_i.
 */
`timescale 1ns/1ps

module fbo_regfile_model (
	// Clock.
	input wire logic mclk_i,
	// Write back from the unit.
	input wire logic res_we_i,
	input wire logic [4:0] res_idx_i,
	input wire logic [7:0] res_data_i,
	// Bench read port.
	input wire logic [4:0] rd_idx_i,
	output logic [7:0] rd_data_o
);
	logic [7:0] regs_reg [32];

	initial begin
		for (int i = 0; i < 32; i++) begin
			regs_reg[i] = 8'h00;
		end
	end

	always @(posedge mclk_i) begin
		if (res_we_i) begin
			regs_reg[res_idx_i] <= res_data_i;
		end
	end

	assign rd_data_o = regs_reg[rd_idx_i];
endmodule

// ### testbench/fbo_unit_test.sv
/*
 * Self-checking bench for the flag and bit operations unit: instructions and
 * software port accesses with expected values, plus a register file model.
 * Assumes the package and both design files are compiled first.
 */
`timescale 1ns/1ps

module fbo_unit_test;
	logic mclk_i = 1'b0;
	logic srst_i = 1'b1;
	logic req_valid_i = 1'b0;
	fbo_pkg::fbo_req_s req_i = '0;
	logic res_we_o;
	logic [4:0] res_idx_o;
	logic [7:0] res_data_o;
	logic [7:0] flags_o;
	logic [1:0] reg_addr_i = 2'h0;
	logic [7:0] reg_wdata_i = 8'h00;
	logic reg_we_i = 1'b0;
	logic reg_re_i = 1'b0;
	logic [7:0] reg_rdata_o;
	logic [7:0] rd_data;
	logic sw_we = 1'b0;
	logic [7:0] sw_wd = 8'h00;
	logic [7:0] fl;
	logic [7:0] r;
	logic [7:0] rv [3] = '{8'h81, 8'h02, 8'h01};
	logic [2:0] pos [6] = '{fbo_pkg::FLAG_CARRY, fbo_pkg::FLAG_NEG, fbo_pkg::FLAG_ZERO,
		fbo_pkg::FLAG_IEN, fbo_pkg::FLAG_SIGN, fbo_pkg::FLAG_OVF};
	int n_mismatch = 0;
	int check_count = 0;
	int cycles = 0;

	always #2.5 mclk_i = ~mclk_i;

	fbo_unit dut_u (.mclk_i(mclk_i), .srst_i(srst_i), .req_valid_i(req_valid_i),
		.req_i(req_i), .res_we_o(res_we_o), .res_idx_o(res_idx_o), .res_data_o(res_data_o),
		.flags_o(flags_o), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
		.reg_we_i(reg_we_i), .reg_re_i(reg_re_i), .reg_rdata_o(reg_rdata_o));

	fbo_regfile_model rf_u (.mclk_i(mclk_i), .res_we_i(res_we_o), .res_idx_i(res_idx_o),
		.res_data_i(res_data_o), .rd_idx_i(5'h1F), .rd_data_o(rd_data));

	task automatic final_report();
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
		check_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask

	// One instruction, optionally with a flags write in the same cycle.
	task automatic op(input fbo_pkg::fbo_op_e c, input logic [7:0] d, input logic [7:0] s,
		input logic [2:0] b);
		@(posedge mclk_i);
		req_valid_i <= 1'b1;
		req_i <= '{op: c, dst_val: d, src_val: s, dst_idx: 5'h1F, bit_idx: b};
		reg_we_i <= sw_we;
		reg_addr_i <= 2'h0;
		reg_wdata_i <= sw_wd;
		@(posedge mclk_i);
		req_valid_i <= 1'b0;
		reg_we_i <= 1'b0;
		#1;
	endtask

	task automatic reg_wr(input logic [1:0] a, input logic [7:0] d);
		@(posedge mclk_i);
		reg_we_i <= 1'b1;
		reg_addr_i <= a;
		reg_wdata_i <= d;
		@(posedge mclk_i);
		reg_we_i <= 1'b0;
	endtask

	task automatic reg_rd(input logic [1:0] a, input logic [7:0] exp);
		@(posedge mclk_i);
		reg_re_i <= 1'b1;
		reg_addr_i <= a;
		@(posedge mclk_i);
		reg_re_i <= 1'b0;
		#1;
		chk8("read data", exp, reg_rdata_o);
	endtask

	// Flags after a rotate or shift: carry, zero, negative, overflow.
	function automatic logic [7:0] shf(input logic [7:0] f, input logic [7:0] q, input logic c);
		return {f[7:4], q[7] ^ c, q[7], q == 8'h00, c};
	endfunction

	always @(posedge mclk_i) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			n_mismatch++;
			final_report();
		end
	end

	initial begin
		repeat (6) @(posedge mclk_i);
		srst_i <= 1'b0;
		@(posedge mclk_i);
		#1;
		chk8("reset flags", fbo_pkg::FLAGS_RST, flags_o);
		chk8("reset result", fbo_pkg::RESULT_RST, res_data_o);
		chk8("reset strobe", 8'h00, {7'h00, res_we_o});
		chk8("reset index", 8'h00, {3'h0, res_idx_o});
		chk8("reset read data", 8'h00, reg_rdata_o);
		reg_wr(2'h0, 8'h00);
		fl = 8'h00;
		foreach (rv[i]) begin
			op(fbo_pkg::OP_ROTATE_RIGHT_CARRY, rv[i], 8'h00, 3'h0);
			r = {fl[0], rv[i][7:1]};
			fl = shf(fl, r, rv[i][0]);
			chk8("rotate result", r, res_data_o);
			chk8("rotate flags", fl, flags_o);
			chk8("write strobe", 8'h01, {7'h00, res_we_o});
			chk8("write index", 8'h1F, {3'h0, res_idx_o});
		end
		for (int i = 0; i < 2; i++) begin
			op(fbo_pkg::OP_ARITH_SHIFT_RIGHT, rv[i] ^ 8'hFF, 8'h00, 3'h0);
			r = rv[i] ^ 8'hFF;
			fl = shf(fl, {r[7], r[7:1]}, r[0]);
			chk8("shift result", {r[7], r[7:1]}, res_data_o);
			chk8("shift flags", fl, flags_o);
		end
		op(fbo_pkg::OP_NIBBLE_SWAP, 8'hA5, 8'h00, 3'h0);
		chk8("swap result", 8'h5A, res_data_o);
		chk8("swap flags", fl, flags_o);
		for (int k = 0; k < 6; k++) begin
			reg_wr(2'h0, 8'h00);
			op(fbo_pkg::fbo_op_e'(5'(8 + 2 * k)), 8'h00, 8'h00, 3'h0);
			chk8("set op", 8'h01 << pos[k], flags_o);
			reg_wr(2'h0, 8'hFF);
			op(fbo_pkg::fbo_op_e'(5'(9 + 2 * k)), 8'h00, 8'h00, 3'h0);
			chk8("clear op", ~(8'h01 << pos[k]), flags_o);
		end
		reg_wr(2'h0, 8'h00);
		fl = 8'h00;
		for (int b = 0; b < 8; b++) begin
			op(fbo_pkg::OP_FLAG_SET, 8'h00, 8'h00, 3'(b));
			fl[b] = 1'b1;
			chk8("flag set", fl, flags_o);
		end
		for (int b = 0; b < 8; b++) begin
			op(fbo_pkg::OP_FLAG_CLEAR, 8'h00, 8'h00, 3'(b));
			fl[b] = 1'b0;
			chk8("flag clear", fl, flags_o);
		end
		op(fbo_pkg::OP_T_STORE, 8'h00, 8'h10, 3'h4);
		chk8("store flags", 8'h40, flags_o);
		chk8("store strobe", 8'h00, {7'h00, res_we_o});
		reg_wr(2'h0, 8'hFF);
		op(fbo_pkg::OP_T_STORE, 8'h00, 8'hF7, 3'h3);
		chk8("store flags", 8'hBF, flags_o);
		op(fbo_pkg::OP_T_LOAD, 8'hFF, 8'h00, 3'h2);
		chk8("load result", 8'hFB, res_data_o);
		chk8("load flags", 8'hBF, flags_o);
		op(fbo_pkg::OP_T_SET, 8'h00, 8'h00, 3'h0);
		chk8("xfer set flags", 8'hFF, flags_o);
		chk8("write back", 8'hFB, rd_data);
		op(fbo_pkg::OP_T_LOAD, 8'h00, 8'h00, 3'h7);
		chk8("load result", 8'h80, res_data_o);
		reg_wr(2'h0, 8'hA4);
		reg_rd(2'h0, 8'hA4);
		reg_rd(2'h1, 8'h80);
		reg_wr(2'h3, 8'hFF);
		reg_rd(2'h2, 8'h00);
		reg_rd(2'h3, 8'h00);
		sw_we = 1'b1;
		sw_wd = 8'h00;
		op(fbo_pkg::OP_CARRY_SET, 8'h00, 8'h00, 3'h0);
		chk8("write against op", 8'hA5, flags_o);
		sw_wd = 8'h3C;
		op(fbo_pkg::OP_NIBBLE_SWAP, 8'h0F, 8'h00, 3'h0);
		sw_we = 1'b0;
		chk8("write beside swap", 8'h3C, flags_o);
		chk8("swap result", 8'hF0, res_data_o);
		@(posedge mclk_i);
		srst_i <= 1'b1;
		repeat (2) @(posedge mclk_i);
		srst_i <= 1'b0;
		@(posedge mclk_i);
		#1;
		chk8("mid reset flags", fbo_pkg::FLAGS_RST, flags_o);
		chk8("mid reset result", fbo_pkg::RESULT_RST, res_data_o);
		chk8("mid reset strobe", 8'h00, {7'h00, res_we_o});
		op(fbo_pkg::OP_ROTATE_RIGHT_CARRY, 8'h01, 8'h00, 3'h0);
		chk8("rotate after reset", 8'h00, res_data_o);
		chk8("flags after reset", 8'h0B, flags_o);
		op(fbo_pkg::fbo_op_e'(5'h1F), 8'hFF, 8'hFF, 3'h7);
		chk8("unknown op flags", 8'h0B, flags_o);
		chk8("unknown op strobe", 8'h00, {7'h00, res_we_o});
		final_report();
	end
endmodule
